/* File: logic/dbw_sram.sv */
// top of the double-rate two-word-burst sram core with per-lane write masking
// assumes K / K# edges are alternate sys_clk cycles, K first after reset
// Contract
// (R1) x8: bits [3:0] written only with lane 0 low, [7:4] only with lane 1 low.
// (R2) x18: lane 0 gates bits [8:0], lane 1 gates [17:9]; unselected bits kept.
// (R3) x9: single select low writes [8:0], high writes nothing for that word.
// (R4) x36: four selects gate [8:0], [17:9], [26:18], [35:27]; high lanes keep contents.
// (R5) all selects high: location untouched for that word, write continues.
// (R6) selects sampled separately for first and second word of a write.
// (R7) write data registered on K and on K# edges.
// (R8) read data launched on output clock pair, or input pair in single clock mode.
// (R9) after reset both ports idle and read data not driven.
// (R10) each burst is two words, offset zero then offset one.
// (R11) controller should park clocks high when stopping them; advisory only.
// (R12) write starts with port select low at K; word 0 at K, word 1 at K#.
// (R13) read started at t: word 0 on C# in t+1, word 1 on C in t+2.
// (R14) read starts with read select low at K; address captured at that edge.
// (R15) each word's own mask applied to its bits before commit to array.
`timescale 1ns/1ps
module dbw_sram
  import dbw_pkg::*;
#(
  parameter int DATA_W = ORG_X18,
  parameter int ADDR_W = 20,
  parameter int LANES  = (DATA_W == ORG_X9) ? 1 : (DATA_W == ORG_X36) ? 4 : 2
)(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              read_port_select_n,
  input  wire logic              write_port_select_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] write_data,
  input  wire logic [LANES-1:0]  byte_lane_write_select_n,
  input  wire logic              single_clock_mode,
  input  wire logic              out_clk_rise,
  input  wire logic              out_clk_n_rise,
  output      logic              k_phase,
  output      logic [DATA_W-1:0] read_data,
  output      logic              read_data_oe
);

  localparam int MW = ADDR_W + 1;

  // ----------------------------------------
  // phase and strap
  // ----------------------------------------
  logic phase;
  logic next_phase;
  logic strap_taken;
  logic next_strap_taken;
  logic single_mode;
  logic next_single_mode;

  always_comb
  begin
    next_phase       = ~phase;
    next_strap_taken = 1'b1;
    // strap caught on the first edge after release, then frozen
    next_single_mode = strap_taken ? single_mode : single_clock_mode;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase       <= PH_K;
      strap_taken <= 1'b0;
      single_mode <= 1'b0;
    end
    else
    begin
      phase       <= next_phase;
      strap_taken <= next_strap_taken;
      single_mode <= next_single_mode;
    end
  end

  assign k_phase = (phase == PH_K);

  // ----------------------------------------
  // write path
  // ----------------------------------------
  dbw_word_s           wr_word;
  logic [DATA_MAX-1:0] full_bit_en;
  logic [DATA_W-1:0]   wr_bit_en;
  logic                mem_we;
  logic [MW-1:0]       mem_waddr;

  dbw_wr_capture #(
    .DATA_W (DATA_W),
    .LANES  (LANES),
    .ADDR_W (ADDR_W)
  ) u_capture (
    .sys_clk                  (sys_clk),
    .rst_n                    (rst_n),
    .phase                    (phase),
    .write_port_select_n      (write_port_select_n),
    .addr                     (addr),
    .write_data               (write_data),
    .byte_lane_write_select_n (byte_lane_write_select_n),
    .word                     (wr_word)
  );

  // nibble lanes for x8, 9-bit lanes otherwise; a high select clears its lane
  // full-width copy kept so checks can name any lane bit whatever the organisation
  assign full_bit_en = lane_bit_enable(wr_word.sel_n, DATA_W);                      // [R1] [R2] [R3] [R4] [R15]
  assign wr_bit_en   = DATA_W'(full_bit_en);
  // a fully masked word never strobes the array
  assign mem_we    = wr_word.valid && (|wr_bit_en);                                 // [R5]
  assign mem_waddr = {wr_word.addr[ADDR_W-1:0], wr_word.offset};                    // [R10]

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // no forwarding from an in-flight write; a same-address read sees the array
  logic              rd1;
  logic              rd2;
  logic              rd3;
  logic              next_rd1;
  logic              next_rd2;
  logic              next_rd3;
  logic [ADDR_W-1:0] rd_addr1;
  logic [ADDR_W-1:0] rd_addr2;
  logic [ADDR_W-1:0] next_rd_addr1;
  logic [ADDR_W-1:0] next_rd_addr2;
  logic [MW-1:0]     mem_raddr;
  logic [DATA_W-1:0] mem_rdata;
  logic [DATA_W-1:0] next_read_data;
  logic              next_read_data_oe;
  logic              launch_pos;
  logic              launch_neg;

  always_comb
  begin
    next_rd1      = (phase == PH_K) && !read_port_select_n;                         // [R14]
    next_rd_addr1 = next_rd1 ? addr : rd_addr1;                                     // [R14]
    next_rd2      = rd1;
    next_rd_addr2 = rd_addr1;
    next_rd3      = rd2;
  end

  // offset zero fetched first, offset one the cycle after
  assign mem_raddr = rd1 ? {rd_addr1, OFS_FIRST} : {rd_addr2, OFS_NEXT};            // [R10]

  dbw_mem #(
    .DW (DATA_W),
    .AW (MW)
  ) u_mem (
    .sys_clk (sys_clk),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (wr_word.data[DATA_W-1:0]),
    .bit_en  (wr_bit_en),
    .raddr   (mem_raddr),
    .rdata   (mem_rdata)
  );

  // output edges come from the input pair in single clock mode
  assign launch_neg = single_mode ? 1'b1 : out_clk_n_rise;                          // [R8]
  assign launch_pos = single_mode ? 1'b1 : out_clk_rise;                            // [R8]

  always_comb
  begin
    next_read_data    = read_data;
    next_read_data_oe = 1'b0;
    // word 0 on the C# edge of t+1, word 1 on the C edge of t+2, then release
    if (rd2 && launch_neg)
    begin
      next_read_data    = mem_rdata;                                                 // [R13]
      next_read_data_oe = 1'b1;
    end
    else if (rd3 && launch_pos)
    begin
      next_read_data    = mem_rdata;                                                 // [R13]
      next_read_data_oe = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd1          <= 1'b0;
      rd2          <= 1'b0;
      rd3          <= 1'b0;
      rd_addr1     <= '0;
      rd_addr2     <= '0;
      read_data    <= READ_DATA_RESET[DATA_W-1:0];
      read_data_oe <= 1'b0;                                                          // [R9]
    end
    else
    begin
      rd1          <= next_rd1;
      rd2          <= next_rd2;
      rd3          <= next_rd3;
      rd_addr1     <= next_rd_addr1;
      rd_addr2     <= next_rd_addr2;
      read_data    <= next_read_data;
      read_data_oe <= next_read_data_oe;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  nibble_lane_mask_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // [R1]
    (DATA_W == ORG_X8 && wr_word.valid && wr_word.sel_n[0]) |-> (wr_bit_en[3:0] == 4'h0))
    else $error("x8 lower nibble written with its select high");

  byte_lane_mask_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // [R2]
    (DATA_W == ORG_X18 && wr_word.valid) |->
      (wr_bit_en[DATA_W-1] == !wr_word.sel_n[1]) && (wr_bit_en[0] == !wr_word.sel_n[0]))
    else $error("x18 lane enables do not follow selects");

  single_lane_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // [R3]
    (DATA_W == ORG_X9 && wr_word.valid) |-> (mem_we == !wr_word.sel_n[0]))
    else $error("x9 write strobe does not follow its select");

  quad_lane_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // [R4]
    (DATA_W == ORG_X36 && wr_word.valid) |->
      (wr_bit_en[DATA_W-1] == !wr_word.sel_n[LANES-1]) && (full_bit_en[BYTE_W] == !wr_word.sel_n[1]))
    else $error("x36 lane enables do not follow selects");

  full_mask_hold_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // [R5]
    (wr_word.valid && (&wr_word.sel_n[LANES-1:0])) |-> !mem_we)
    else $error("array written with every lane deselected");

  per_word_mask_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // [R6]
    wr_word.valid |-> (wr_word.sel_n[LANES-1:0] == $past(byte_lane_write_select_n)))
    else $error("word mask is not the one sampled with it");

  write_data_take_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // [R7]
    wr_word.valid |-> (wr_word.data[DATA_W-1:0] == $past(write_data)))
    else $error("write word differs from data at its edge");

  write_burst_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // [R12]
    (k_phase && !write_port_select_n && !wr_word.valid) |->
      ##1 (wr_word.valid && wr_word.offset == OFS_FIRST) ##1 (wr_word.valid && wr_word.offset == OFS_NEXT))
    else $error("write burst not taken on K then K#");

  read_burst_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // [R13]
    (single_mode && k_phase && !read_port_select_n) |-> ##3 read_data_oe ##1 read_data_oe)
    else $error("read words not launched at t+1 C# and t+2 C");

  read_addr_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // [R14]
    (k_phase && !read_port_select_n) |-> ##1 (mem_raddr == {$past(addr), OFS_FIRST}) ##1 (mem_raddr[0] == OFS_NEXT))
    else $error("read address not taken at K or burst order wrong");

  reset_idle_a : assert property (@(posedge sys_clk) // [R9]
    $rose(rst_n) |-> (!read_data_oe && !wr_word.valid && !rd1))
    else $error("ports not deselected after reset");

  upper_nibble_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // [R1]
    (DATA_W == ORG_X8 && wr_word.valid && wr_word.sel_n[1]) |-> (full_bit_en[7:4] == 4'h0))
    else $error("x8 upper nibble written with its select high");

  single_lane_bits_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // [R3]
    (DATA_W == ORG_X9 && wr_word.valid) |-> (full_bit_en[BYTE_W-1:0] == {BYTE_W{!wr_word.sel_n[0]}}))
    else $error("x9 word not written whole or not at all");

  lower_lanes_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // [R4]
    (DATA_W == ORG_X36 && wr_word.valid) |->
      (full_bit_en[2*BYTE_W] == !wr_word.sel_n[2]) && (full_bit_en[0] == !wr_word.sel_n[0]))
    else $error("x36 lower lane enables do not follow selects");

  second_word_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // [R12]
    (wr_word.valid && wr_word.offset == OFS_FIRST) |-> ##1 (wr_word.valid && wr_word.offset == OFS_NEXT))
    else $error("first write word not followed by the second");

  burst_address_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // [R10]
    (wr_word.valid && wr_word.offset == OFS_NEXT) |->
      (mem_waddr[0] == OFS_NEXT) && (wr_word.addr == $past(wr_word.addr)))
    else $error("second write word not at offset one of the same address");

  k_edge_write_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // [R12]
    !k_phase |-> ##1 !(wr_word.valid && wr_word.offset == OFS_FIRST))
    else $error("write started on a K# edge");

  k_edge_read_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // [R14]
    !k_phase |-> ##1 !rd1)
    else $error("read started on a K# edge");

  phase_toggle_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // [R7]
    1'b1 |-> ##1 (k_phase != $past(k_phase)))
    else $error("K and K# cycles do not alternate");

  strap_frozen_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // [R8]
    strap_taken |-> ##1 $stable(single_mode))
    else $error("clock mode strap changed during operation");

  read_order_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // [R10]
    rd2 |-> (mem_raddr == {rd_addr2, OFS_NEXT}))
    else $error("second read word not fetched from offset one");

  // oe low stands for the undriven bus, so it must drop as soon as no word is due
  word0_launch_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // [R13]
    (rd2 && launch_neg) |-> ##1 (read_data_oe && (read_data == $past(mem_rdata))))
    else $error("first read word not launched on its output edge");

  word1_launch_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // [R13]
    (rd3 && launch_pos) |-> ##1 (read_data_oe && (read_data == $past(mem_rdata))))
    else $error("second read word not launched on its output edge");

  output_release_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // [R9]
    (!rd2 && !rd3) |-> ##1 !read_data_oe)
    else $error("read data driven with no read word due");

endmodule : dbw_sram

/* File: logic/dbw_pkg.sv */
// shared constants, types and lane decoding for the double-rate write-masked sram core
// assumes one system clock; the K / K# input edges are alternate system clock cycles
package dbw_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int DATA_MAX  = 36;
  localparam int LANE_MAX  = 4;
  localparam int ADDR_MAX  = 24;
  localparam int NIBBLE_W  = 4;
  localparam int BYTE_W    = 9;
  localparam int ORG_X8    = 8;
  localparam int ORG_X9    = 9;
  localparam int ORG_X18   = 18;
  localparam int ORG_X36   = 36;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int K_PERIOD_PS   = 2 * CLK_PERIOD_PS;
  localparam int HALF_CYCLES   = K_PERIOD_PS / (2 * CLK_PERIOD_PS);

  // ----------------------------------------
  // phases and reset values
  // ----------------------------------------
  localparam logic PH_K      = 1'b0;
  localparam logic PH_KN     = 1'b1;
  localparam logic OFS_FIRST = 1'b0;
  localparam logic OFS_NEXT  = 1'b1;
  localparam logic [DATA_MAX-1:0] READ_DATA_RESET = 36'h0_0000_0000;

  typedef enum logic [0:0] {WR_IDLE, WR_SECOND} dbw_wr_state_e;

  // one captured write word with its own lane mask
  typedef struct packed {
    logic                valid;
    logic                offset;
    logic [ADDR_MAX-1:0] addr;
    logic [DATA_MAX-1:0] data;
    logic [LANE_MAX-1:0] sel_n;
  } dbw_word_s;

  // ----------------------------------------
  // lane select to bit enable
  // ----------------------------------------
  // x8 uses nibble lanes, every other organisation uses 9-bit lanes
  function automatic logic [DATA_MAX-1:0] lane_bit_enable(input logic [LANE_MAX-1:0] sel_n,
                                                          input int                  data_w);
    logic [DATA_MAX-1:0] en;
    int                  lane;
    en = '0;
    for (int i = 0; i < DATA_MAX; i++)
    begin
      lane  = (data_w == ORG_X8) ? i / NIBBLE_W : i / BYTE_W;
      en[i] = (i < data_w) && (lane < LANE_MAX) && !sel_n[lane[1:0]];
    end
    return en;
  endfunction : lane_bit_enable

endpackage : dbw_pkg

/* File: logic/dbw_mem.sv */
// word array with per-bit write enable and a registered read port
// assumes one write and one read per clock; read of a word being written returns old data
`timescale 1ns/1ps
module dbw_mem
  import dbw_pkg::*;
#(
  parameter int DW = 18,
  parameter int AW = 21
)(
  input  wire logic          sys_clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [DW-1:0] bit_en,
  input  wire logic [AW-1:0] raddr,
  output      logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // ----------------------------------------
  // array
  // ----------------------------------------
  // disabled bits are simply not touched, so masked lanes keep old contents
  always_ff @(posedge sys_clk)
  begin
    if (we)
    begin
      for (int i = 0; i < DW; i++)
      begin
        if (bit_en[i])
          mem[waddr][i] <= wdata[i];
      end
    end
    rdata <= mem[raddr];
  end

endmodule : dbw_mem

/* File: logic/dbw_wr_capture.sv */
// write port input register: takes data and lane selects on the K and the K# edge
// assumes phase marks the K cycle with PH_K and alternates every clock
`timescale 1ns/1ps
module dbw_wr_capture
  import dbw_pkg::*;
#(
  parameter int DATA_W = 18,
  parameter int LANES  = 2,
  parameter int ADDR_W = 20
)(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              phase,
  input  wire logic              write_port_select_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] write_data,
  input  wire logic [LANES-1:0]  byte_lane_write_select_n,
  output      dbw_word_s         word
);

  dbw_wr_state_e       state;
  dbw_wr_state_e       next_state;
  dbw_word_s           next_word;
  logic [ADDR_MAX-1:0] held_addr;
  logic [ADDR_MAX-1:0] next_held_addr;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    next_state     = state;
    next_held_addr = held_addr;
    next_word      = word;
    next_word.valid = 1'b0;
    // data and selects always sampled here, so each word keeps its own mask
    next_word.data  = DATA_MAX'(write_data);                                       // [R7]
    next_word.sel_n = LANE_MAX'(~(~byte_lane_write_select_n));                     // [R6]
    case (state)
      WR_IDLE:
      begin
        if (phase == PH_K && !write_port_select_n)                                 // [R12]
        begin
          next_state       = WR_SECOND;
          next_held_addr   = ADDR_MAX'(addr);
          next_word.valid  = 1'b1;
          next_word.offset = OFS_FIRST;
          next_word.addr   = ADDR_MAX'(addr);
        end
      end
      WR_SECOND:
      begin
        // second word on the following K# edge, same latched address
        next_state       = WR_IDLE;
        next_word.valid  = 1'b1;                                                   // [R12]
        next_word.offset = OFS_NEXT;                                               // [R10]
        next_word.addr   = held_addr;
      end
      default:
      begin
        next_state = WR_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state     <= WR_IDLE;
      held_addr <= '0;
      word      <= '0;
    end
    else
    begin
      state     <= next_state;
      held_addr <= next_held_addr;
      word      <= next_word;
    end
  end

endmodule : dbw_wr_capture

/* File: sim/dbw_ctrl_model.sv */
// controller-side model: drives write and read bursts into one sram core and checks every read word
// assumes K cycles are the even cycles after reset release and one request per K cycle
`timescale 1ns/1ps
module dbw_ctrl_model
  import dbw_pkg::*;
#(
  parameter int DW  = 18,
  parameter int LN  = 2,
  parameter int AW  = 4,
  parameter bit SCM = 1'b1,
  parameter int OPS = 200
)(
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic          k_phase,
  input  wire logic [DW-1:0] read_data,
  input  wire logic          read_data_oe,
  output      logic          read_port_select_n,
  output      logic          write_port_select_n,
  output      logic [AW-1:0] addr,
  output      logic [DW-1:0] write_data,
  output      logic [LN-1:0] byte_lane_write_select_n,
  output      logic          single_clock_mode,
  output      logic          out_clk_rise,
  output      logic          out_clk_n_rise,
  output      int            err_cnt,
  output      int            chk_cnt,
  output      logic          done
);
  logic [DW-1:0] exp_mem [2**(AW+1)];
  logic [DW-1:0] exp_q [$];
  int            due_q [$];
  int            cyc;
  int            op;
  logic          kc;
  logic          rs;
  logic          ws;
  logic          wr2;
  logic          fin;
  logic [AW-1:0] a;
  logic [AW-1:0] wa;
  logic [DW-1:0] d;
  logic [LN-1:0] m;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // x8 has nibble lanes, all other widths 9-bit lanes
  function automatic logic [DW-1:0] lane_mask(input logic [LN-1:0] sel_n);
    logic [DW-1:0] mk;
    for (int i = 0; i < DW; i++)
      mk[i] = !sel_n[(DW == ORG_X8) ? i / NIBBLE_W : i / BYTE_W];
    return mk;
  endfunction : lane_mask

  task automatic merge(input logic [AW:0] i, input logic [DW-1:0] di, input logic [LN-1:0] mi);
    logic [DW-1:0] mk;
    mk         = lane_mask(mi);
    exp_mem[i] = (exp_mem[i] & ~mk) | (di & mk);
  endtask : merge

  task automatic check(input string what, input logic [DW-1:0] exp, input logic [DW-1:0] got);
    chk_cnt++;
    if (got !== exp)
    begin
      err_cnt++;
      $display("wrong value %s width %0d expected %h seen %h", what, DW, exp, got);
    end
  endtask : check

  // ----------------------------------------
  // drive and check
  // ----------------------------------------
  initial
  begin
    read_port_select_n       = 1'b1;
    write_port_select_n      = 1'b1;
    addr                     = '0;
    write_data               = '0;
    byte_lane_write_select_n = '1;
    single_clock_mode        = SCM;
    out_clk_rise             = 1'b0;
    out_clk_n_rise           = 1'b0;
    err_cnt                  = 0;
    chk_cnt                  = 0;
    done                     = 1'b0;
    op                       = 0;
    wr2                      = 1'b0;
  end

  always @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      cyc <= 0;
    else
      cyc <= cyc + 1;

  always @(negedge sys_clk)
  begin
    if (!rst_n)
    begin
      check("oe_in_reset", '0, DW'(read_data_oe));
      check("k_phase_in_reset", DW'(1), DW'(k_phase));
    end
    else if (!done)
    begin
      kc = (cyc % 2 == 0);
      check("k_phase", DW'(kc), DW'(k_phase));
      if (due_q.size() > 0 && due_q[0] == cyc)
      begin
        check("read_data_oe", DW'(1), DW'(read_data_oe));
        check("read_data", exp_q.pop_front(), read_data);
        void'(due_q.pop_front());
      end
      else
        check("idle_oe", '0, DW'(read_data_oe));
      d  = DW'({$urandom(), $urandom()});
      m  = LN'($urandom());
      a  = AW'($urandom());
      rs = 1'b1;
      ws = 1'b1;
      if (!kc)
      begin
        // selects in the second half are noise the core must ignore
        {rs, ws} = 2'($urandom());
        // the fill pass writes both words whole, so no array bit is left unknown
        if (op <= 2**AW)
          m = '0;
        if (wr2)
          merge({wa, OFS_NEXT}, d, m);
      end
      else if (op < 2**AW)
      begin
        a  = AW'(op);
        m  = '0;
        ws = 1'b0;
      end
      else if (op < 2**AW + OPS)
      begin
        ws = 1'($urandom_range(1));
        rs = !ws;
      end
      if (kc && !ws)
      begin
        merge({a, OFS_FIRST}, d, m);
        wa = a;
      end
      if (kc && !rs)
      begin
        due_q.push_back(cyc + 3);
        due_q.push_back(cyc + 4);
        exp_q.push_back(exp_mem[{a, OFS_FIRST}]);
        exp_q.push_back(exp_mem[{a, OFS_NEXT}]);
      end
      op                       = op + int'(kc);
      wr2                      = kc && !ws;
      fin                      = (op > 2**AW + OPS) && (due_q.size() == 0);
      read_port_select_n       = rs;
      write_port_select_n      = ws;
      addr                     = a;
      write_data               = d;
      byte_lane_write_select_n = m;
      out_clk_n_rise           = kc || fin;
      out_clk_rise             = !kc || fin;
      done                     = fin;
    end
  end
endmodule : dbw_ctrl_model

/* File: sim/testbench.sv */
// top of the bench: one core and one controller model for each of the x8, x9, x18 and x36 widths
// assumes the controller model does all stimulus and comparison; this module adds clock, reset, verdict
`timescale 1ns/1ps
module testbench;
  import dbw_pkg::*;
  localparam int LIMIT = 1500;
  logic sys_clk;
  logic rst_n;
  int   err_v [4];
  int   chk_v [4];
  logic done_v [4];
  int   fails;
  int   total_checks;
  int   cycles;

  // ----------------------------------------
  // one core per organisation
  // ----------------------------------------
  // x18 runs with output strobes, the rest in single clock mode
  for (genvar g = 0; g < 4; g++)
  begin : g_org
    localparam int DW = (g == 0) ? ORG_X8 : (g == 1) ? ORG_X9 : (g == 2) ? ORG_X18 : ORG_X36;
    localparam int LN = (DW == ORG_X9) ? 1 : (DW == ORG_X36) ? 4 : 2;
    logic          rd_sel_n;
    logic          wr_sel_n;
    logic [3:0]    addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    logic [LN-1:0] lane_n;
    logic          scm;
    logic          c_rise;
    logic          cn_rise;
    logic          kph;
    logic          oe;
    dbw_sram #(.DATA_W(DW), .ADDR_W(4)) i_dbw_sram (
      .sys_clk(sys_clk), .rst_n(rst_n), .read_port_select_n(rd_sel_n), .write_port_select_n(wr_sel_n),
      .addr(addr), .write_data(wdata), .byte_lane_write_select_n(lane_n), .single_clock_mode(scm),
      .out_clk_rise(c_rise), .out_clk_n_rise(cn_rise), .k_phase(kph), .read_data(rdata), .read_data_oe(oe));
    dbw_ctrl_model #(.DW(DW), .LN(LN), .AW(4), .SCM(g != 2)) i_dbw_ctrl_model (
      .sys_clk(sys_clk), .rst_n(rst_n), .k_phase(kph), .read_data(rdata), .read_data_oe(oe),
      .read_port_select_n(rd_sel_n), .write_port_select_n(wr_sel_n), .addr(addr), .write_data(wdata),
      .byte_lane_write_select_n(lane_n), .single_clock_mode(scm), .out_clk_rise(c_rise),
      .out_clk_n_rise(cn_rise), .err_cnt(err_v[g]), .chk_cnt(chk_v[g]), .done(done_v[g]));
  end

  // ----------------------------------------
  // clock, reset, verdict
  // ----------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #(CLK_PERIOD_PS / 2000.0) sys_clk = ~sys_clk;
  end

  task automatic final_report();
    for (int g = 0; g < 4; g++)
    begin
      fails        = fails + err_v[g];
      total_checks = total_checks + chk_v[g];
    end
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  initial
  begin
    fails        = 0;
    total_checks = 0;
    cycles       = 0;
    rst_n        = 1'b0;
    void'($urandom(32'h8c6d5062));
    repeat (5) @(negedge sys_clk);
    rst_n <= 1'b1;
    wait (done_v[0] && done_v[1] && done_v[2] && done_v[3]);
    final_report();
  end

  // a hung handshake would otherwise run forever
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      fails++;
      $display("wrong value run_done expected %0d seen %0d", 1, 0);
      final_report();
    end
  end
endmodule : testbench
